// >>> rtl/pmra_pkg.sv
//------------------------------------------------------------------------------
// power monitor results and alert: shared constants and types
//------------------------------------------------------------------------------
package pmra_pkg;

   //---------------------------------------------------------------------------
   // register access
   //---------------------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 24;
   localparam int WR_W   = 16;

   localparam logic [ADDR_W-1:0] OFS_ADC_CONFIG = 5'h01;
   localparam logic [ADDR_W-1:0] OFS_DIE_TEMP   = 5'h06;
   localparam logic [ADDR_W-1:0] OFS_CURRENT    = 5'h07;
   localparam logic [ADDR_W-1:0] OFS_POWER      = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_DIAG       = 5'h0b;

   //---------------------------------------------------------------------------
   // field positions
   //---------------------------------------------------------------------------
   localparam int TEMP_W         = 12;
   localparam int TEMP_LSB       = 4;
   localparam int MODE_LSB       = 12;
   localparam int MODE_W         = 4;
   localparam int CFG_LSB        = 12;
   localparam int BIT_OVF        = 9;
   localparam int LIM_LSB        = 2;
   localparam int LIM_N          = 6;
   localparam int BIT_CONV_DONE  = 1;
   localparam int BIT_TRIM_OK    = 0;

   // index of each flag inside the limit flag vector
   localparam int LIM_TEMP_OVER   = 5;
   localparam int LIM_SHUNT_OVER  = 4;
   localparam int LIM_SHUNT_UNDER = 3;
   localparam int LIM_BUS_OVER    = 2;
   localparam int LIM_BUS_UNDER   = 1;
   localparam int LIM_POWER_OVER  = 0;

   localparam logic [MODE_W-1:0] MODE_TRIG_MIN = 4'h1;
   localparam logic [MODE_W-1:0] MODE_TRIG_MAX = 4'h7;

   //---------------------------------------------------------------------------
   // reset values
   //---------------------------------------------------------------------------
   localparam logic [15:0]       DIAG_RESET    = 16'h0001;
   localparam logic [TEMP_W-1:0] TEMP_RESET    = 12'h000;
   localparam logic [15:0]       CURRENT_RESET = 16'h0000;
   localparam logic [23:0]       POWER_RESET   = 24'h00_0000;

   //---------------------------------------------------------------------------
   // carriers
   //---------------------------------------------------------------------------
   typedef struct packed {
      logic [TEMP_W-1:0] temp;
      logic [15:0]       shunt;
      logic [15:0]       bus;
      logic [15:0]       current;
      logic [23:0]       power;
   } pmra_meas_t;

   typedef struct packed {
      logic [TEMP_W-1:0] temp;
      logic [15:0]       shuntOver;
      logic [15:0]       shuntUnder;
      logic [14:0]       busOver;
      logic [14:0]       busUnder;
      logic [23:0]       power;
   } pmra_limits_t;

   typedef struct packed {
      logic              rdEn;
      logic              wrEn;
      logic [ADDR_W-1:0] addr;
      logic [WR_W-1:0]   wrData;
   } pmra_reg_req_t;

   typedef struct packed {
      logic latchSelect;
      logic readyOnAlertEnable;
      logic averagedCompareSelect;
      logic alertPolarity;
   } pmra_cfg_t;

   typedef struct packed {
      pmra_cfg_t         cfg;
      logic [LIM_N-1:0]  limFlags;
      logic              convDoneFlag;
      logic              arithOverflowFlag;
      logic              trimMemoryOk;
      logic [TEMP_W-1:0] dieTempField;
      logic [15:0]       current;
      logic [23:0]       power;
      logic [DATA_W-1:0] rdData;
      logic              rdValid;
      logic              alertOe;
      logic              convStart;
   } pmra_state_t;

endpackage : pmra_pkg

// >>> rtl/pmra_limit_cmp.sv
`timescale 1ns/1ps
`default_nettype none

module pmra_limit_cmp #(
   parameter int W         = 16,
   parameter bit IS_SIGNED = 1'b1,
   parameter bit IS_OVER   = 1'b1
) (
   // operands
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] limit,
   // result
   output logic              hit
);

   logic greater;
   logic less;

   always_comb begin
      if (IS_SIGNED) begin
         greater = $signed(value) > $signed(limit);
         less    = $signed(value) < $signed(limit);
      end else begin
         greater = value > limit;
         less    = value < limit;
      end
      hit = IS_OVER ? greater : less;
   end

endmodule // pmra_limit_cmp

`default_nettype wire

// >>> rtl/pmra_results_alert.sv
//------------------------------------------------------------------------------
// Overview of operation
// - die temperature sits in bits 15-4, signed, 125 mC per count, bits 3-0 zero
// - current result is a 16-bit signed read-only register
// - power result is a 24-bit unsigned read-only register
// - transparent mode: flags and alert follow the latest comparison
// - latched mode: flags and alert hold until diagnostic read, which clears them
// - ready-on-alert enable lets conversion done drive the alert
// - averaged-compare select picks raw or averaged values for limit checks
// - polarity bit: zero active low, one active high, open drain
// - arithmetic overflow sets the overflow flag
// - overflow flag holds until a new triggered conversion; reads keep it
// - temperature above its limit sets the over-temperature flag
// - shunt above its over limit sets the shunt over flag
// - shunt below its under limit sets the shunt under flag
// - bus above its over limit sets the bus over flag
// - bus below its under limit sets the bus under flag
// - power above its limit sets the power over flag
// - conversion end sets done flag; latched read or trigger clears it
// - trim memory ok resets to one, falls to zero on checksum error
// - diagnostic bits 11, 10 and 8 read zero
// - writing a triggered mode starts one conversion, clearing dependent flags
// - temperature limit compares directly with the temperature field
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module pmra_results_alert
   import pmra_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // register access from the serial front end
   input  wire pmra_reg_req_t       regReq,
   output logic [DATA_W-1:0]        regRdData,
   output logic                     regRdValid,
   // conversion engine
   input  wire logic                rawValid,
   input  wire pmra_meas_t          rawMeas,
   input  wire logic                avgValid,
   input  wire pmra_meas_t          avgMeas,
   input  wire logic                arithOverflow,
   input  wire logic                trimChecksumError,
   output logic                     convStart,
   // thresholds
   input  wire pmra_limits_t        limits,
   // alert pin, open drain
   output logic                     alertOut,
   output logic                     alertOe
);

   //---------------------------------------------------------------------------
   // reset release
   //---------------------------------------------------------------------------
   logic rstMeta;
   logic rstSyncN;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta  <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta  <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   //---------------------------------------------------------------------------
   // limit comparison
   //---------------------------------------------------------------------------
   pmra_state_t      st;
   pmra_state_t      next_st;
   pmra_meas_t       cmpMeas;
   logic             cmpStrobe;
   logic [LIM_N-1:0] viol;

   // averaged select holds off comparison until averaging completes
   assign cmpStrobe = st.cfg.averagedCompareSelect ? avgValid : rawValid;
   assign cmpMeas   = st.cfg.averagedCompareSelect ? avgMeas : rawMeas;

   pmra_limit_cmp #(.W(TEMP_W), .IS_SIGNED(1'b1), .IS_OVER(1'b1)) u_temp_over (
      .value (cmpMeas.temp),
      .limit (limits.temp),
      .hit   (viol[LIM_TEMP_OVER])
   );
   pmra_limit_cmp #(.W(16), .IS_SIGNED(1'b1), .IS_OVER(1'b1)) u_shunt_over (
      .value (cmpMeas.shunt),
      .limit (limits.shuntOver),
      .hit   (viol[LIM_SHUNT_OVER])
   );
   pmra_limit_cmp #(.W(16), .IS_SIGNED(1'b1), .IS_OVER(1'b0)) u_shunt_under (
      .value (cmpMeas.shunt),
      .limit (limits.shuntUnder),
      .hit   (viol[LIM_SHUNT_UNDER])
   );
   pmra_limit_cmp #(.W(16), .IS_SIGNED(1'b0), .IS_OVER(1'b1)) u_bus_over (
      .value (cmpMeas.bus),
      .limit ({1'b0, limits.busOver}),
      .hit   (viol[LIM_BUS_OVER])
   );
   pmra_limit_cmp #(.W(16), .IS_SIGNED(1'b0), .IS_OVER(1'b0)) u_bus_under (
      .value (cmpMeas.bus),
      .limit ({1'b0, limits.busUnder}),
      .hit   (viol[LIM_BUS_UNDER])
   );
   pmra_limit_cmp #(.W(24), .IS_SIGNED(1'b0), .IS_OVER(1'b1)) u_power_over (
      .value (cmpMeas.power),
      .limit (limits.power),
      .hit   (viol[LIM_POWER_OVER])
   );

   //---------------------------------------------------------------------------
   // register decode
   //---------------------------------------------------------------------------
   logic              rdDiag;
   logic              wrDiag;
   logic              trigStart;
   logic [MODE_W-1:0] wrMode;

   assign wrMode = regReq.wrData[MODE_LSB +: MODE_W];
   assign rdDiag = regReq.rdEn && (regReq.addr == OFS_DIAG);
   assign wrDiag = regReq.wrEn && (regReq.addr == OFS_DIAG);
   assign trigStart = regReq.wrEn && (regReq.addr == OFS_ADC_CONFIG) &&
                      (wrMode >= MODE_TRIG_MIN) && (wrMode <= MODE_TRIG_MAX);

   function automatic logic [15:0] diag_word(input pmra_state_t s);
      logic [15:0] w;
      w                         = 16'h0000;
      w[CFG_LSB +: 4]           = s.cfg;
      w[BIT_OVF]                = s.arithOverflowFlag;
      w[LIM_LSB +: LIM_N]       = s.limFlags;
      w[BIT_CONV_DONE]          = s.convDoneFlag;
      w[BIT_TRIM_OK]            = s.trimMemoryOk;
      return w;
   endfunction

   //---------------------------------------------------------------------------
   // next state
   //---------------------------------------------------------------------------
   logic alertActive;

   always_comb begin
      next_st           = st;
      next_st.convStart = trigStart;

      if (wrDiag) begin
         next_st.cfg = regReq.wrData[CFG_LSB +: 4];
      end

      // limit flags: a new violation wins over a read clear
      if (st.cfg.latchSelect) begin
         next_st.limFlags = (st.limFlags & ~{LIM_N{rdDiag}}) |
                            (cmpStrobe ? viol : {LIM_N{1'b0}});
      end else if (cmpStrobe) begin
         next_st.limFlags = viol;
      end

      next_st.convDoneFlag = (st.convDoneFlag &
                              ~(trigStart | (st.cfg.latchSelect & rdDiag))) |
                             avgValid;

      next_st.arithOverflowFlag = (st.arithOverflowFlag & ~trigStart) |
                                  arithOverflow;

      next_st.trimMemoryOk = st.trimMemoryOk & ~trimChecksumError;

      if (avgValid) begin
         next_st.dieTempField = avgMeas.temp;
         next_st.current      = avgMeas.current;
         next_st.power        = avgMeas.power;
      end

      next_st.rdValid = regReq.rdEn;
      if (!regReq.rdEn) begin
         next_st.rdData = st.rdData;
      end else if (regReq.addr == OFS_DIE_TEMP) begin
         next_st.rdData = {8'h00, st.dieTempField, 4'h0};
      end else if (regReq.addr == OFS_CURRENT) begin
         next_st.rdData = {8'h00, st.current};
      end else if (regReq.addr == OFS_POWER) begin
         next_st.rdData = st.power;
      end else if (regReq.addr == OFS_DIAG) begin
         next_st.rdData = {8'h00, diag_word(st)};
      end else begin
         next_st.rdData = 24'h00_0000;
      end

      alertActive = (|next_st.limFlags) |
                    (next_st.cfg.readyOnAlertEnable & next_st.convDoneFlag);
      // open drain: active low pulls while active, active high pulls while idle
      next_st.alertOe = alertActive ^ next_st.cfg.alertPolarity;
   end

   //---------------------------------------------------------------------------
   // state register
   //---------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         st              <= '0;
         st.cfg          <= DIAG_RESET[CFG_LSB +: 4];
         st.trimMemoryOk <= DIAG_RESET[BIT_TRIM_OK];
         st.dieTempField <= TEMP_RESET;
         st.current      <= CURRENT_RESET;
         st.power        <= POWER_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign regRdData  = st.rdData;
   assign regRdValid = st.rdValid;
   assign convStart  = st.convStart;
   assign alertOe    = st.alertOe;

   // the pin is only ever pulled low; the level itself is a constant flop
   logic alertLevel;
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         alertLevel <= 1'b0;
      end else begin
         alertLevel <= 1'b0;
      end
   end
   assign alertOut = alertLevel;

   //---------------------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstSyncN);

   logic activeNow;
   assign activeNow = (|st.limFlags) | (st.cfg.readyOnAlertEnable & st.convDoneFlag);

   a_temp_low_zero: assert property (
      regReq.rdEn && regReq.addr == OFS_DIE_TEMP |=>
         regRdValid && regRdData[3:0] == 4'h0 && regRdData[23:16] == 8'h00)
      else $error("temperature low bits not zero");

   a_result_capture: assert property (
      avgValid |=> st.current == $past(avgMeas.current) && st.power == $past(avgMeas.power))
      else $error("results not captured at conversion end");

   a_transp_follow: assert property (
      !st.cfg.latchSelect && cmpStrobe |=> st.limFlags == $past(viol))
      else $error("transparent flags do not follow comparison");

   a_latch_hold: assert property (
      st.cfg.latchSelect && !wrDiag && !rdDiag |=> (st.limFlags & $past(st.limFlags))
         == $past(st.limFlags))
      else $error("latched flag dropped without a read");

   a_read_clears: assert property (
      st.cfg.latchSelect && rdDiag && !cmpStrobe && !wrDiag |=> st.limFlags == '0)
      else $error("diagnostic read did not clear latched flags");

   a_alert_polarity: assert property (
      alertOe == (activeNow ^ st.cfg.alertPolarity))
      else $error("alert enable disagrees with flags and polarity");

   a_ovf_hold: assert property (
      st.arithOverflowFlag && !trigStart |=> st.arithOverflowFlag)
      else $error("overflow flag cleared without a trigger");

   a_ovf_clear: assert property (
      trigStart && !arithOverflow |=> !st.arithOverflowFlag)
      else $error("trigger did not clear overflow flag");

   a_trim_sticky: assert property (
      !st.trimMemoryOk |=> !st.trimMemoryOk [*3])
      else $error("trim memory status recovered");

   a_diag_reserved: assert property (
      rdDiag |=> regRdData[11:10] == 2'b00 && regRdData[8] == 1'b0)
      else $error("reserved diagnostic bits set");

   a_ovf_set: assert property (
      arithOverflow |=> st.arithOverflowFlag)
      else $error("overflow flag not set");

   // back-to-back triggers are legal, so the second cycle follows the request
   a_start_pulse: assert property (
      trigStart |=> convStart ##1 (convStart == $past(trigStart)))
      else $error("conversion start is not a single pulse");

   a_done_set: assert property (
      avgValid |=> st.convDoneFlag)
      else $error("conversion done flag not set");

   a_temp_capture: assert property (
      avgValid |=> st.dieTempField == $past(avgMeas.temp))
      else $error("temperature result not captured");

   a_ready_alert: assert property (
      avgValid && st.cfg.readyOnAlertEnable && !wrDiag |=> alertOe != st.cfg.alertPolarity)
      else $error("conversion done did not drive the alert");

   c_latched_clear: cover property (st.cfg.latchSelect && |st.limFlags ##1 rdDiag);
   c_overflow_set: cover property (arithOverflow ##1 st.arithOverflowFlag);
   c_ready_alert: cover property (st.cfg.readyOnAlertEnable && avgValid ##1 activeNow);
   c_trigger_start: cover property (trigStart ##1 convStart);

endmodule // pmra_results_alert

`default_nettype wire

// >>> tb/pmra_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pmra_host_model
   import pmra_pkg::*;
(
   // clock
   input  wire logic              ref_clk,
   // command from the bench
   input  wire logic              go,
   input  wire logic              isWrite,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [WR_W-1:0]   wrData,
   // device side
   output pmra_reg_req_t          regReq,
   input  wire logic [DATA_W-1:0] regRdData,
   input  wire logic              regRdValid,
   // answer to the bench
   output logic [DATA_W-1:0]      rdData,
   output logic                   done
);
   initial begin
      regReq = '0;
      rdData = '0;
      done = 1'b0;
   end

   // idle address and data lines toggle so a stale value is never trusted
   always @(posedge ref_clk) begin
      if (go) begin
         regReq <= '{rdEn: !isWrite, wrEn: isWrite, addr: addr, wrData: wrData};
      end else begin
         regReq <= '{rdEn: 1'b0, wrEn: 1'b0, addr: ~regReq.addr, wrData: ~regReq.wrData};
      end
      done <= regRdValid;
      if (regRdValid) begin
         rdData <= regRdData;
      end
   end
endmodule // pmra_host_model

`default_nettype wire

// >>> tb/pmra_results_alert_bench.sv
`timescale 1ns/1ps
`default_nettype none

module pmra_results_alert_bench
   import pmra_pkg::*;
;
   typedef struct packed {
      pmra_meas_t  meas;
      logic [15:0] expFlags;
   } pmra_row_t;

   logic              ref_clk = 1'b0;
   logic              rst_n = 1'b1;
   logic              rawValid = 1'b0;
   logic              avgValid = 1'b0;
   pmra_meas_t        rawMeas = '0;
   pmra_meas_t        avgMeas = '0;
   logic              arithOverflow = 1'b0;
   logic              trimChecksumError = 1'b0;
   pmra_limits_t      limits = '{12'h100, 16'h1000, 16'hF000, 15'h2000, 15'h0100, 24'h00_8000};
   logic              go = 1'b0;
   logic              isWrite = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [WR_W-1:0]   wrData = '0;
   pmra_reg_req_t     regReq;
   logic [DATA_W-1:0] regRdData;
   logic              regRdValid;
   logic              convStart;
   logic              alertOut;
   logic              alertOe;
   logic [DATA_W-1:0] rdData;
   logic              done;
   int                nMismatch = 0;
   int                comparisons = 0;
   int                startCount = 0;
   int                s;
   pmra_meas_t        base = '{12'h050, 16'h0000, 16'h1000, 16'h0000, 24'h00_0100};
   pmra_meas_t        viol = '{12'h050, 16'h1001, 16'h1000, 16'h0000, 24'h00_0100};
   pmra_meas_t        res  = '{12'hABC, 16'h0000, 16'h1000, 16'h8123, 24'hFE_DCBA};
   pmra_row_t         rows [10] = '{
      '{'{12'h101, 16'h0000, 16'h1000, 16'h0000, 24'h00_0100}, 16'h0080},
      '{'{12'h100, 16'h0000, 16'h1000, 16'h0000, 24'h00_0100}, 16'h0000},
      '{'{12'hF00, 16'h0000, 16'h1000, 16'h0000, 24'h00_0100}, 16'h0000},
      '{'{12'h050, 16'h1001, 16'h1000, 16'h0000, 24'h00_0100}, 16'h0040},
      '{'{12'h050, 16'hEFFF, 16'h1000, 16'h0000, 24'h00_0100}, 16'h0020},
      '{'{12'h050, 16'h0000, 16'h2001, 16'h0000, 24'h00_0100}, 16'h0010},
      '{'{12'h050, 16'h0000, 16'h00FF, 16'h0000, 24'h00_0100}, 16'h0008},
      '{'{12'h050, 16'h0000, 16'h1000, 16'h0000, 24'h00_8001}, 16'h0004},
      '{'{12'h050, 16'h0000, 16'h1000, 16'h0000, 24'hFF_0000}, 16'h0004},
      '{'{12'h050, 16'h0000, 16'h1000, 16'h0000, 24'h00_0100}, 16'h0000}};

   always #25 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      if (convStart === 1'b1) begin
         startCount++;
      end
   end

   pmra_results_alert dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
      .regRdValid(regRdValid), .rawValid(rawValid), .rawMeas(rawMeas),
      .avgValid(avgValid), .avgMeas(avgMeas), .arithOverflow(arithOverflow),
      .trimChecksumError(trimChecksumError), .convStart(convStart), .limits(limits),
      .alertOut(alertOut), .alertOe(alertOe));

   pmra_host_model host (
      .ref_clk(ref_clk), .go(go), .isWrite(isWrite), .addr(addr), .wrData(wrData),
      .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
      .rdData(rdData), .done(done));

   //---------------------------------------------------------------------------
   // shared tasks
   //---------------------------------------------------------------------------
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         nMismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      go <= 1'b1;
      isWrite <= wr;
      addr <= a;
      wrData <= d;
      @(posedge ref_clk);
      go <= 1'b0;
      if (wr) begin
         repeat (3) @(posedge ref_clk);
      end else begin
         for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            #1;
            if (done === 1'b1) break;
         end
      end
   endtask

   task automatic strobe(input logic raw, input logic avg, input pmra_meas_t m);
      @(posedge ref_clk);
      rawValid <= raw;
      avgValid <= avg;
      rawMeas <= m;
      avgMeas <= m;
      @(posedge ref_clk);
      rawValid <= 1'b0;
      avgValid <= 1'b0;
      rawMeas <= ~m;
      avgMeas <= ~m;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic reset_and_check;
      logic [4:0]  ra [5];
      logic [23:0] re [5];
      ra = '{OFS_DIE_TEMP, OFS_CURRENT, OFS_POWER, OFS_DIAG, 5'h1F};
      re = '{24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0001, 24'h00_0000};
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < 5; i++) begin
         access(1'b0, ra[i], 16'h0000);
         check("reset value", rdData, re[i]);
      end
      check("alert idle", {23'h0, alertOe}, 24'h00_0000);
      check("alert level", {23'h0, alertOut}, 24'h00_0000);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
      if (nMismatch == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   //---------------------------------------------------------------------------
   // main sequence
   //---------------------------------------------------------------------------
   initial begin
      reset_and_check();
      foreach (rows[i]) begin
         strobe(1'b1, 1'b0, rows[i].meas);
         check("alert", {23'h0, alertOe}, {23'h0, rows[i].expFlags != 16'h0000});
         access(1'b0, OFS_DIAG, 16'h0000);
         check("flags", rdData & 24'h00_00FC, {8'h00, rows[i].expFlags});
      end
      check("done", rdData & 24'h00_0002, 24'h00_0000);
      strobe(1'b0, 1'b1, res);
      access(1'b0, OFS_DIE_TEMP, 16'h0000);
      check("temp", rdData, 24'h00_ABC0);
      access(1'b0, OFS_CURRENT, 16'h0000);
      check("current", rdData, 24'h00_8123);
      access(1'b0, OFS_POWER, 16'h0000);
      check("power", rdData, 24'hFE_DCBA);
      access(1'b0, OFS_DIAG, 16'h0000);
      check("done", rdData & 24'h00_0002, 24'h00_0002);
      // transparent mode: a read leaves the done flag standing
      access(1'b0, OFS_DIAG, 16'h0000);
      check("done", rdData & 24'h00_0002, 24'h00_0002);
      access(1'b1, OFS_DIAG, 16'h4000);
      check("ready alert", {23'h0, alertOe}, 24'h00_0001);
      access(1'b1, OFS_DIAG, 16'h0000);
      check("ready alert", {23'h0, alertOe}, 24'h00_0000);
      access(1'b1, OFS_DIAG, 16'h1000);
      check("polarity", {23'h0, alertOe}, 24'h00_0001);
      strobe(1'b1, 1'b0, viol);
      check("polarity", {23'h0, alertOe}, 24'h00_0000);
      access(1'b1, OFS_DIAG, 16'h8000);
      strobe(1'b1, 1'b0, base);
      check("latched alert", {23'h0, alertOe}, 24'h00_0001);
      access(1'b0, OFS_DIAG, 16'h0000);
      check("latched", rdData & 24'h00_00FE, 24'h00_0042);
      access(1'b0, OFS_DIAG, 16'h0000);
      check("latched", rdData & 24'h00_00FE, 24'h00_0000);
      check("latched alert", {23'h0, alertOe}, 24'h00_0000);
      access(1'b1, OFS_DIAG, 16'h2000);
      strobe(1'b1, 1'b0, viol);
      access(1'b0, OFS_DIAG, 16'h0000);
      check("averaged", rdData & 24'h00_00FC, 24'h00_0000);
      strobe(1'b0, 1'b1, viol);
      access(1'b0, OFS_DIAG, 16'h0000);
      check("averaged", rdData & 24'h00_00FE, 24'h00_0042);
      @(posedge ref_clk);
      arithOverflow <= 1'b1;
      @(posedge ref_clk);
      arithOverflow <= 1'b0;
      access(1'b0, OFS_DIAG, 16'h0000);
      check("overflow", rdData & 24'h00_0200, 24'h00_0200);
      check("reserved", rdData & 24'h00_0D00, 24'h00_0000);
      access(1'b0, OFS_DIAG, 16'h0000);
      check("overflow", rdData & 24'h00_0200, 24'h00_0200);
      for (int m = 0; m < 16; m++) begin
         s = startCount;
         access(1'b1, OFS_ADC_CONFIG, {m[3:0], 12'h000});
         check("starts", 24'(startCount - s), 24'(m >= 1 && m <= 7));
      end
      access(1'b0, OFS_DIAG, 16'h0000);
      check("trigger clear", rdData & 24'h00_0202, 24'h00_0000);
      @(posedge ref_clk);
      trimChecksumError <= 1'b1;
      @(posedge ref_clk);
      trimChecksumError <= 1'b0;
      access(1'b0, OFS_DIAG, 16'h0000);
      check("trim", rdData & 24'h00_0001, 24'h00_0000);
      reset_and_check();
      give_verdict();
   end

   initial begin
      #(50 * 5000);
      nMismatch++;
      give_verdict();
   end
endmodule // pmra_results_alert_bench

`default_nettype wire
